// File: core_cycle_regs.vh
// Register indices, field positions, reset values and timing constants of the core block
`ifndef CORE_CYCLE_REGS_VH
`define CORE_CYCLE_REGS_VH

// ============================================================
// Register indices (byte address is four times the index)
`define IDX_PC_LOW          8'h02
`define IDX_CORE_STATUS     8'h03
`define IDX_IND_POINTER     8'h04
`define IDX_PC_UPPER        8'h0A
`define IDX_RUN_CTRL        8'h10
`define IDX_PC_VIEW         8'h11
`define IDX_EXEC_VIEW       8'h12

// ============================================================
// Field positions
`define BIT_BANK_LOW        5
`define BIT_BANK_HIGH       6
`define BIT_IND_HIGH        7
`define BIT_RUN             0

// ============================================================
// Reset values
`define RST_CORE_STATUS     8'h00
`define RST_IND_POINTER     8'h00
`define RST_PC_UPPER        8'h00
`define RST_RUN             1'b1
`define RESET_VECTOR        13'h0000
`define IRQ_VECTOR          13'h0004

// ============================================================
// Timing and data memory layout
`define PHASES_PER_CYCLE    4
`define SFR_TOP             7'h20
`define COMMON_BASE         7'h70
`define BANK2_SMALL_TOP     7'h50
`define RAM_COMMON_BASE     8'h50
`define RAM_BANK1_BASE      8'h60
`define RAM_BANK2_BASE      8'hB0

`endif

// File: core_cycle_and_memory_map.v
// Instruction-cycle sequencer, program address wrap and banked data memory decode
`default_nettype none
`include "core_cycle_regs.vh"

// What this block does
// - Clock divided into four one-hot phases
// - Program counter steps in phase one
// - Fetched word latched in phase four
// - Fetched instruction presented at next phase one
// - Fetch overlaps execute, one instruction per cycle
// - Counter-changing instructions flush, taking two cycles
// - Operand read phase two, result write phase four
// - Thirteen-bit counter, 8K word logical space
// - Addresses wrap into implemented program memory
// - Reset starts at zero, interrupt vectors four
// - Four banks, low 32 are special registers
// - Bank two RAM size depends on variant
// - Top sixteen bytes shared by all banks
// - Two status bits select the bank for direct access
// - Register file 224 or 256 bytes, direct/indirect
module core_cycle_and_memory_map #(
    parameter PROG_ADDR_BITS = 12,
    parameter LARGE_RAM      = 1
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [13:0] prog_rdata,
    input  wire        jump_req,
    input  wire [10:0] jump_target,
    input  wire        irq_req,
    input  wire        result_we,
    input  wire [7:0]  result_wdata,
    output wire        phase_one,
    output wire        phase_two,
    output wire        phase_three,
    output wire        phase_four,
    output reg  [12:0] prog_addr_q,
    output reg  [13:0] instruction_latch,
    output reg         exec_valid_q,
    output reg  [8:0]  data_addr_q,
    output reg  [7:0]  ram_index_q,
    output reg         ram_sel_q,
    output reg         sfr_sel_q,
    output reg  [7:0]  core_rdata_q,
    output reg         data_rd_q,
    output reg         data_wr_q,
    output reg  [7:0]  data_wdata_q,
    output reg         irq_ack_q
);

    // ============================================================
    // Phase states
    localparam [3:0] PH_ONE   = 4'h1;
    localparam [3:0] PH_TWO   = 4'h2;
    localparam [3:0] PH_THREE = 4'h4;
    localparam [3:0] PH_FOUR  = 4'h8;

    // ============================================================
    // Program space wrap
    // Only 10 to 12 address bits make sense; larger would not wrap at all
    localparam [12:0] PROG_MASK = (13'h0001 << PROG_ADDR_BITS) - 13'h0001;

    // ============================================================
    // Core register offsets, decoded in every bank
    localparam [7:0] CORE_PC_LOW   = `IDX_PC_LOW;
    localparam [7:0] CORE_STATUS   = `IDX_CORE_STATUS;
    localparam [7:0] CORE_POINTER  = `IDX_IND_POINTER;
    localparam [7:0] CORE_PC_UPPER = `IDX_PC_UPPER;

    // Sequencer and pipeline state
    reg  [3:0]  phase_q;
    reg  [12:0] pc_q;
    reg  [13:0] fetch_q;
    reg         fetch_valid_q;
    reg         redirect_q;
    reg  [12:0] target_q;
    // Core and control registers
    reg  [7:0]  status_q;
    reg  [7:0]  pointer_q;
    reg  [7:0]  pc_upper_q;
    reg         run_q;

    // Decode helpers
    wire [6:0]  fetch_off;
    wire [8:0]  logical_addr;
    wire [8:0]  ram_map;
    wire        core_hit;
    wire [6:0]  wr_off;
    wire        wr_core;
    wire [7:0]  apb_idx;
    wire        apb_aligned;
    wire        apb_access;
    reg  [31:0] apb_mux;
    reg         apb_hit;

    assign phase_one   = phase_q[0];
    assign phase_two   = phase_q[1];
    assign phase_three = phase_q[2];
    assign phase_four  = phase_q[3];

    // ============================================================
    // Data address forming and decode
    // Offset zero is the indirect slot; its ninth address bit lives in status
    assign fetch_off    = fetch_q[6:0];
    assign logical_addr = (fetch_off == 7'h00) ?
                          {status_q[`BIT_IND_HIGH], pointer_q} :
                          {status_q[`BIT_BANK_HIGH], status_q[`BIT_BANK_LOW],
                           fetch_off};

    // Returns {select, physical index}; bank three owns only the shared bytes
    function [8:0] map_ram;
        input [8:0] a;
        reg   [6:0] o;
        reg   [6:0] rel;
        begin
            o       = a[6:0];
            rel     = o - `SFR_TOP;
            map_ram = 9'h000;
            if (o >= `COMMON_BASE) begin
                map_ram = {1'b1, `RAM_COMMON_BASE + {4'h0, o[3:0]}};
            end else if (o >= `SFR_TOP) begin
                case (a[8:7])
                    2'b00: map_ram = {1'b1, 1'b0, rel};
                    2'b01: map_ram = {1'b1, `RAM_BANK1_BASE + {1'b0, rel}};
                    2'b10: begin
                        if (LARGE_RAM != 0 || o < `BANK2_SMALL_TOP) begin
                            map_ram = {1'b1, `RAM_BANK2_BASE + {1'b0, rel}};
                        end
                    end
                    default: map_ram = 9'h000;
                endcase
            end
        end
    endfunction

    function is_core;
        input [6:0] o;
        begin
            case ({1'b0, o})
                CORE_PC_LOW,
                CORE_STATUS,
                CORE_POINTER,
                CORE_PC_UPPER: is_core = 1'b1;
                default:       is_core = 1'b0;
            endcase
        end
    endfunction

    assign ram_map  = map_ram(logical_addr);
    assign core_hit = is_core(logical_addr[6:0]);
    assign wr_off   = data_addr_q[6:0];
    assign wr_core  = data_wr_q && is_core(wr_off);

    // ============================================================
    // APB decode
    // Upper address bits and byte lanes must be zero, else the slave errors
    assign apb_idx     = paddr[9:2];
    assign apb_aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
    assign apb_access  = psel && penable && pready;

    // Views of the counter and the executing word are read-only
    always @* begin
        apb_mux = 32'h0000_0000;
        apb_hit = apb_aligned;
        case (apb_idx)
            `IDX_PC_LOW:      apb_mux = {24'h00_0000, pc_q[7:0]};
            `IDX_CORE_STATUS: apb_mux = {24'h00_0000, status_q};
            `IDX_IND_POINTER: apb_mux = {24'h00_0000, pointer_q};
            `IDX_PC_UPPER:    apb_mux = {24'h00_0000, pc_upper_q};
            `IDX_RUN_CTRL:    apb_mux = {31'h0000_0000, run_q};
            `IDX_PC_VIEW:     apb_mux = {19'h0_0000, pc_q};
            `IDX_EXEC_VIEW:   apb_mux = {17'h0_0000, exec_valid_q, instruction_latch};
            default:          apb_hit = 1'b0;
        endcase
        if (!apb_aligned) begin
            apb_mux = 32'h0000_0000;
        end
    end

    // Zero-wait slave: ready rises in the access phase, one cycle after setup
    // Writes read back zero on the bus; unmapped offsets raise an error
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= pwrite ? 32'h0000_0000 : apb_mux;
            pready  <= 1'b1;
            pslverr <= !apb_hit;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ============================================================
    // Phase sequencer
    // Clearing run freezes phases and pipeline; the bus still answers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= PH_ONE;
        end else if (run_q) begin
            case (phase_q)
                PH_ONE:   phase_q <= PH_TWO;
                PH_TWO:   phase_q <= PH_THREE;
                PH_THREE: phase_q <= PH_FOUR;
                PH_FOUR:  phase_q <= PH_ONE;
                default:  phase_q <= PH_ONE;
            endcase
        end
    end

    // ============================================================
    // Pipeline, core registers and data strobes
    // Core register writes from software land after the pipeline's own, so software wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q              <= `RESET_VECTOR;
            prog_addr_q       <= `RESET_VECTOR;
            fetch_q           <= 14'h0000;
            fetch_valid_q     <= 1'b0;
            instruction_latch <= 14'h0000;
            exec_valid_q      <= 1'b0;
            redirect_q        <= 1'b0;
            target_q          <= `RESET_VECTOR;
            data_addr_q       <= 9'h000;
            ram_index_q       <= 8'h00;
            ram_sel_q         <= 1'b0;
            sfr_sel_q         <= 1'b0;
            core_rdata_q      <= 8'h00;
            data_rd_q         <= 1'b0;
            data_wr_q         <= 1'b0;
            data_wdata_q      <= 8'h00;
            irq_ack_q         <= 1'b0;
            status_q          <= `RST_CORE_STATUS;
            pointer_q         <= `RST_IND_POINTER;
            pc_upper_q        <= `RST_PC_UPPER;
            run_q             <= `RST_RUN;
        end else begin
            if (run_q) begin
                case (phase_q)
                    PH_ONE: begin
                        if (redirect_q) begin
                            // Flushed cycle: the prefetched word is dropped, no operand read
                            prog_addr_q  <= target_q & PROG_MASK;
                            pc_q         <= target_q + 13'h0001;
                            exec_valid_q <= 1'b0;
                            data_rd_q    <= 1'b0;
                        end else begin
                            prog_addr_q  <= pc_q & PROG_MASK;
                            pc_q         <= pc_q + 13'h0001;
                            exec_valid_q <= fetch_valid_q;
                            data_rd_q    <= fetch_valid_q;
                        end
                        redirect_q        <= 1'b0;
                        irq_ack_q         <= 1'b0;
                        instruction_latch <= fetch_q;
                        data_addr_q       <= logical_addr;
                        ram_sel_q         <= ram_map[8] && !core_hit;
                        ram_index_q       <= ram_map[7:0];
                        sfr_sel_q         <= (logical_addr[6:0] < `SFR_TOP) && !core_hit;
                        // Snapshot of a core register for the phase two operand read
                        case ({1'b0, logical_addr[6:0]})
                            CORE_PC_LOW:   core_rdata_q <= pc_q[7:0];
                            CORE_STATUS:   core_rdata_q <= status_q;
                            CORE_POINTER:  core_rdata_q <= pointer_q;
                            CORE_PC_UPPER: core_rdata_q <= pc_upper_q;
                            default:               core_rdata_q <= 8'h00;
                        endcase
                    end
                    PH_TWO: begin
                        // Operand read strobe lasts exactly phase two
                        data_rd_q <= 1'b0;
                    end
                    PH_THREE: begin
                        // Result taken late so the write strobe falls in phase four
                        data_wr_q    <= exec_valid_q && result_we;
                        data_wdata_q <= result_wdata;
                    end
                    PH_FOUR: begin
                        data_wr_q     <= 1'b0;
                        fetch_q       <= prog_rdata;
                        fetch_valid_q <= 1'b1;
                        // A counter byte write is handled below as a redirect
                        if (wr_core) begin
                            case ({1'b0, wr_off})
                                CORE_STATUS:   status_q   <= data_wdata_q;
                                CORE_POINTER:  pointer_q  <= data_wdata_q;
                                CORE_PC_UPPER: pc_upper_q <= data_wdata_q;
                                default:               status_q   <= status_q;
                            endcase
                        end
                        // One redirect per cycle: jump beats a counter write, then interrupt
                        if (exec_valid_q && jump_req) begin
                            redirect_q <= 1'b1;
                            target_q   <= {pc_upper_q[4:3], jump_target};
                        end else if (wr_core && {1'b0, wr_off} == CORE_PC_LOW) begin
                            redirect_q <= 1'b1;
                            target_q   <= {pc_upper_q[4:0], data_wdata_q};
                        end else if (irq_req) begin
                            redirect_q <= 1'b1;
                            target_q   <= `IRQ_VECTOR;
                            irq_ack_q  <= 1'b1;
                        end
                    end
                    default: begin
                        // Only reached on an illegal phase code
                        data_rd_q <= 1'b0;
                        data_wr_q <= 1'b0;
                    end
                endcase
            end
            // Software writes come last so they override the pipeline's
            if (apb_access && pwrite && apb_aligned) begin
                case (apb_idx)
                    `IDX_CORE_STATUS: status_q   <= pwdata[7:0];
                    `IDX_IND_POINTER: pointer_q  <= pwdata[7:0];
                    `IDX_PC_UPPER:    pc_upper_q <= pwdata[7:0];
                    `IDX_RUN_CTRL:    run_q      <= pwdata[`BIT_RUN];
                    `IDX_PC_LOW: begin
                        redirect_q <= 1'b1;
                        target_q   <= {pc_upper_q[4:0], pwdata[7:0]};
                    end
                    default: run_q <= run_q;
                endcase
            end
        end
    end

endmodule // core_cycle_and_memory_map
`default_nettype wire

// File: core_cycle_monitor.sv
// Assertion checker bound to the core cycle and memory map block
`default_nettype none
module core_cycle_monitor #(
    parameter int PROG_ADDR_BITS = 12
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        phase_one,
    input wire logic        phase_two,
    input wire logic        phase_three,
    input wire logic        phase_four,
    input wire logic [12:0] prog_addr_q,
    input wire logic [13:0] prog_rdata,
    input wire logic [13:0] instruction_latch,
    input wire logic        exec_valid_q,
    input wire logic        jump_req,
    input wire logic [10:0] jump_target,
    input wire logic        irq_req,
    input wire logic        irq_ack_q,
    input wire logic        result_we,
    input wire logic [7:0]  result_wdata,
    input wire logic        data_rd_q,
    input wire logic        data_wr_q,
    input wire logic [7:0]  data_wdata_q
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [12:0] MASK = (13'h0001 << PROG_ADDR_BITS) - 13'h0001;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================================
    // Cycle sequencing
    AST_ONE_HOT: assert property ($onehot({phase_one, phase_two, phase_three, phase_four}))
        else $error("phases not one-hot");
    AST_PHASE_ORDER: assert property (phase_one |=> phase_two ##1 phase_three ##1 phase_four ##1 phase_one)
        else $error("phase order broken");
    AST_PC_STEP: assert property (phase_two && exec_valid_q |-> prog_addr_q == (($past(prog_addr_q, 4) + 13'h0001) & MASK))
        else $error("counter did not step by one");
    AST_WRAP: assert property ((prog_addr_q & ~MASK) == 13'h0000)
        else $error("program address beyond implemented space");
    AST_FETCH: assert property (phase_two && exec_valid_q |-> instruction_latch == $past(prog_rdata, 2))
        else $error("fetched word not presented");
    AST_READ: assert property (data_rd_q == (phase_two && exec_valid_q))
        else $error("operand read outside phase two");
    AST_WRITE: assert property (data_wr_q == (phase_four && exec_valid_q && $past(result_we)))
        else $error("result write outside phase four");
    AST_WDATA: assert property (data_wr_q |-> data_wdata_q == $past(result_wdata))
        else $error("result data wrong");
    AST_JUMP: assert property (phase_four && jump_req && exec_valid_q |-> ##2 (!exec_valid_q && prog_addr_q == ({2'b00, $past(jump_target, 2)} & MASK)))
        else $error("jump not flushed to target");
    AST_IRQ: assert property (phase_four && irq_req && !(jump_req && exec_valid_q) |-> ##1 irq_ack_q ##1 (!exec_valid_q && prog_addr_q == 13'h0004))
        else $error("interrupt vector not taken");
    AST_ACK: assert property (irq_ack_q |-> phase_one)
        else $error("acknowledge outside phase one");
endmodule // core_cycle_monitor

bind core_cycle_and_memory_map core_cycle_monitor #(.PROG_ADDR_BITS(PROG_ADDR_BITS)) mon (.*);
`default_nettype wire

// File: prog_mem_model.sv
// Program memory model answering in the same cycle
`default_nettype none
module prog_mem_model (
    input  wire logic [12:0] prog_addr_q,
    output var  logic [13:0] prog_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Offsets stay odd and above 10h, so fetched words never hit core registers
    always_comb prog_rdata = {prog_addr_q[6:0], prog_addr_q[5:0] | 6'h08, 1'b1};
endmodule // prog_mem_model
`default_nettype wire

// File: core_cycle_and_memory_map_test.sv
// Self-checking bench for the core cycle and memory map block
`default_nettype none
module core_cycle_and_memory_map_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [32:0] FULL = 33'h1_FFFF_FFFF;
    localparam logic [32:0] ERR  = 33'h1_0000_0000;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, quiet;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [13:0] prog_rdata, instruction_latch;
    logic        jump_req, irq_req, result_we, exec_valid_q, ram_sel_q, sfr_sel_q;
    logic        phase_one, phase_two, phase_three, phase_four, data_rd_q, data_wr_q, irq_ack_q;
    logic [10:0] jump_target;
    logic [7:0]  result_wdata, ram_index_q, core_rdata_q, data_wdata_q, st_now, st_at, d;
    logic [12:0] prog_addr_q;
    logic [8:0]  data_addr_q, ea;
    logic [32:0] ev, mv;
    logic [32:0] eq[$], mq[$];
    int          n_mismatch, tests_run;

    core_cycle_and_memory_map #(.PROG_ADDR_BITS(11), .LARGE_RAM(0)) dut (.*);
    prog_mem_model pm (.prog_addr_q(prog_addr_q), .prog_rdata(prog_rdata));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // ==========================================================
    // Checking
    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Expected {special hit, ram hit, ram index} of a logical data address
    function automatic logic [9:0] dmap(input logic [8:0] a);
        logic [7:0] o;
        o = {1'b0, a[6:0]};
        if (o < 8'h20) return {(o != 8'h02 && o != 8'h03 && o != 8'h04 && o != 8'h0A), 9'h000};
        if (o >= 8'h70) return {2'b01, o - 8'h20};
        case (a[8:7])
            2'h0: return {2'b01, o - 8'h20};
            2'h1: return {2'b01, o + 8'h40};
            2'h2: return (o < 8'h50) ? {2'b01, o + 8'h90} : 10'h000;
            default: return 10'h000;
        endcase
    endfunction
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && eq.size() > 0) begin
            ev = eq.pop_front();
            mv = mq.pop_front();
            chk("apb read", ev & mv, {pslverr, prdata} & mv);
        end
        if (phase_one === 1'b1) st_at <= st_now;
        if (data_rd_q === 1'b1) begin
            ea = {st_at[6:5], instruction_latch[6:0]};
            chk("data address", {24'h0, ea}, {24'h0, data_addr_q});
            chk("data decode", {23'h0, dmap(ea)}, {23'h0, sfr_sel_q, ram_sel_q, ram_sel_q ? ram_index_q : 8'h00});
            chk("core read data", 33'h0, {25'h0, core_rdata_q});
        end
    end
    // ==========================================================
    // Stimulus
    always @(posedge pclk) begin
        jump_req     <= !quiet && ($urandom % 4 == 0);
        jump_target  <= 11'($urandom);
        irq_req      <= !quiet && ($urandom % 7 == 0);
        result_we    <= 1'($urandom);
        result_wdata <= 8'($urandom);
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                        input logic [32:0] e, input logic [32:0] m);
        if (!w) begin
            eq.push_back(e);
            mq.push_back(m);
        end
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        if (w && a == 12'h00C) st_now <= wd[7:0];
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {jump_req, irq_req, result_we, jump_target, result_wdata} = '0;
        {n_mismatch, tests_run} = '0;
        {st_now, st_at, presetn, quiet} = {16'h0000, 1'b0, 1'b1};
        void'($urandom(32'hCF2ABBF0));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("reset vector", 33'h0, {19'h0, exec_valid_q, prog_addr_q});
        xfer(0, 12'h00C, 0, 33'h0, FULL);
        xfer(0, 12'h010, 0, 33'h0, FULL);
        xfer(0, 12'h028, 0, 33'h0, FULL);
        xfer(0, 12'h040, 0, 33'h1, FULL);
        xfer(0, 12'h014, 0, ERR, ERR);
        xfer(0, 12'h00D, 0, ERR, ERR);
        xfer(1, 12'h044, 32'hFFFF_FFFF, 0, 0);
        xfer(0, 12'h044, 0, 33'h0, ERR);
        // Redirect through the low counter byte lands at upper bits 5 plus the written byte, inside the small program space
        d = 8'($urandom);
        xfer(1, 12'h028, 32'h0000_0005, 0, 0);
        xfer(0, 12'h028, 0, 33'h5, FULL);
        xfer(1, 12'h008, {24'h0, d}, 0, 0);
        do @(posedge pclk); while (phase_one !== 1'b1);
        @(posedge pclk);
        chk("pc low redirect", {22'h0, 3'h5, d}, {19'h0, exec_valid_q, prog_addr_q});
        quiet <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            d = (8'($urandom) & 8'h9F) | {1'b0, i[1:0], 5'h00};
            xfer(1, 12'h00C, {24'h0, d}, 0, 0);
            xfer(0, 12'h00C, 0, {25'h0, d}, 33'h1_0000_00E0);
            xfer(1, 12'h010, {24'h0, ~d}, 0, 0);
            xfer(0, 12'h010, 0, {25'h0, ~d}, FULL);
            repeat (40) @(posedge pclk);
        end
        give_verdict();
    end
    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end
endmodule // core_cycle_and_memory_map_test
`default_nettype wire
